/* rtl/fpc_regs.svh */
// Register offsets, field positions, reset values and counts
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH
// ==========================================================
// Offsets
`define FPC_OFS_DATA 8'hf6
`define FPC_OFS_GUARD 8'hfa
`define FPC_OFS_IRQ 8'hfb
`define FPC_OFS_PAGE 8'hfc
`define FPC_OFS_ROW 8'hfd
`define FPC_OFS_COL 8'hfe
`define FPC_OFS_PGCTL 8'hff
// ==========================================================
// Reset values and locked mask load value
`define FPC_RST_GUARD 8'hff
`define FPC_RST_IRQ 8'h00
`define FPC_RST_PAGE 8'h00
`define FPC_LOCKED_GUARD 8'hff
// ==========================================================
// Interrupt control fields
`define FPC_IRQ_COMPLETION_IRQ_ENABLE 7
`define FPC_IRQ_ERROR_IRQ_ENABLE 6
`define FPC_IRQ_DONE 5
`define FPC_IRQ_WR_VIOL 3
`define FPC_IRQ_TMO 2
`define FPC_IRQ_PG_VIOL 1
`define FPC_IRQ_ARR_VIOL 0
// ==========================================================
// Page select and program control fields
`define FPC_PAGE_INFO 7
`define FPC_CMD_ROW 2
`define FPC_CMD_PAGE 1
`define FPC_CMD_ARRAY 0
// ==========================================================
// Timing in flash controller clocks
`define FPC_ROW_PROGRAM_TIMEOUT_FLAG_TICKS 4864
`endif

/* rtl/fpc_pkg.sv */
// Types shared by the flash guard controller
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_IDLE = 2'b00,
    FPC_ARRAY = 2'b01,
    FPC_PAGE = 2'b10,
    FPC_ROW = 2'b11
  } fpc_op_t;
  typedef logic [17:0] fpc_addr_t;
endpackage : fpc_pkg

/* rtl/fpc_tmo_if.sv */
// Link between the controller and its row program timer
`timescale 1ns/1ns
interface fpc_tmo_if;
  logic run;
  logic tick;
  logic expire;
  modport ctrl (output run, output tick, input expire);
  modport timer (input run, input tick, output expire);
endinterface : fpc_tmo_if

/* rtl/fpc_rp_timer.sv */
// Row program watchdog counting flash controller clocks
`timescale 1ns/1ns
`include "fpc_regs.svh"
module fpc_rp_timer #(
  parameter int unsigned TICKS = `FPC_ROW_PROGRAM_TIMEOUT_FLAG_TICKS,
  parameter int unsigned CW = 13
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  fpc_tmo_if.timer tmo
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic exp_r;
  logic exp_nxt;

  // ==========================================================
  // Counter
  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = 1'b0;
    if (!tmo.run) begin
      cnt_nxt = '0;
    end else if (tmo.tick && !exp_r) begin
      if (cnt_r == CW'(TICKS - 1)) begin
        exp_nxt = 1'b1;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign tmo.expire = exp_r;
endmodule : fpc_rp_timer

/* rtl/fpc_ctrl.sv */
// Flash guard, event flags and page select controller
// Functional notes
// - Eight 32 KB blocks; a set mask bit refuses writes and erases.
// - Mask bit n guards the block starting at n times 32 KB.
// - After reset all eight mask bits are set.
// - Boot block guarded when write-protect pin asserted or mask bit 0 set.
// - Mask write while locked loads FFh instead of the written value.
// - Info page has no guard bit; kept out of array erase by select bit.
// - Completion interrupt enabled by bit 7, error interrupt by bit 6.
// - Row program over 4864 flash controller clocks aborts, clears bit 2, flags.
// - Write to guarded block is suppressed and sets write violation bit 3.
// - Page erase of guarded block not done; sets violation bit 1.
// - Array erase with any guarded block not done; sets bit 0.
// - With error enable set, any of four error flags requests interrupt.
// - Completion flag bit 5 set when erase or row program finishes.
// - Reading interrupt control clears bits 5 and 3..0; bits 7,6 writable.
// - Write-protect pin fails page erase of block 0 and any array erase.
// - Info select 1 steers access and page erase to info page.
// - Low seven page bits pick one of 128 pages; ignored when info set.
// - Every data port access increments the page, row, column address.
// - Command bits 2,1,0 start row program, page erase, array erase.
`timescale 1ns/1ns
`include "fpc_regs.svh"
module fpc_ctrl #(
  parameter int unsigned ROW_PROGRAM_TIMEOUT_FLAG_TICKS = `FPC_ROW_PROGRAM_TIMEOUT_FLAG_TICKS
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic guard_unlocked_i,
  input wire logic wp_pin_i,
  input wire logic fclk_tick_i,
  input wire logic mem_wr_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic [7:0] arr_rdata_i,
  input wire logic arr_done_i,
  output logic arr_wr_o,
  output logic [17:0] arr_addr_o,
  output logic [7:0] arr_wdata_o,
  output logic arr_info_o,
  output logic arr_page_erase_o,
  output logic arr_array_erase_o,
  output logic arr_row_prog_o,
  output logic done_irq_o,
  output logic err_irq_o
);
  // ==========================================================
  // Guard decode
  function automatic logic blk_guarded(input logic [7:0] mask,
                                       input logic wp,
                                       input logic [2:0] blk);
    blk_guarded = mask[blk] || (wp && blk == 3'h0);
  endfunction : blk_guarded

  // ==========================================================
  // Pin synchroniser
  logic wp_s1_r;
  logic wp_s2_r;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_s1_r <= 1'b0;
      wp_s2_r <= 1'b0;
    end else begin
      wp_s1_r <= wp_pin_i;
      wp_s2_r <= wp_s1_r;
    end
  end

  // ==========================================================
  // State
  logic [7:0] guard_r;
  logic [7:0] guard_nxt;
  logic [1:0] ien_r;
  logic [1:0] ien_nxt;
  logic done_r;
  logic done_nxt;
  logic [3:0] err_r;
  logic [3:0] err_nxt;
  logic info_r;
  logic info_nxt;
  logic [6:0] page_r;
  logic [6:0] page_nxt;
  logic [2:0] row_r;
  logic [2:0] row_nxt;
  logic [7:0] col_r;
  logic [7:0] col_nxt;
  fpc_pkg::fpc_op_t op_r;
  fpc_pkg::fpc_op_t op_nxt;
  logic wr_r;
  logic wr_nxt;
  logic [17:0] waddr_r;
  logic [17:0] waddr_nxt;
  logic [7:0] wdata_r;
  logic [7:0] wdata_nxt;
  logic pe_r;
  logic pe_nxt;
  logic ae_r;
  logic ae_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  fpc_tmo_if tmo ();
  assign tmo.run = (op_r == fpc_pkg::FPC_ROW);
  assign tmo.tick = fclk_tick_i;

  fpc_rp_timer #(
    .TICKS(ROW_PROGRAM_TIMEOUT_FLAG_TICKS),
    .CW(13)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .tmo(tmo)
  );

  // ==========================================================
  // Access decode
  logic hit_data;
  logic wr_guard;
  logic wr_irq;
  logic wr_page;
  logic wr_row;
  logic wr_col;
  logic wr_cmd;
  logic rd_irq;
  fpc_pkg::fpc_addr_t io_addr;
  fpc_pkg::fpc_addr_t io_addr_inc;
  logic any_guard;

  assign hit_data = (io_addr_i == `FPC_OFS_DATA) && (io_wr_i || io_rd_i);
  assign wr_guard = io_wr_i && io_addr_i == `FPC_OFS_GUARD;
  assign wr_irq = io_wr_i && io_addr_i == `FPC_OFS_IRQ;
  assign wr_page = io_wr_i && io_addr_i == `FPC_OFS_PAGE;
  assign wr_row = io_wr_i && io_addr_i == `FPC_OFS_ROW;
  assign wr_col = io_wr_i && io_addr_i == `FPC_OFS_COL;
  assign wr_cmd = io_wr_i && io_addr_i == `FPC_OFS_PGCTL;
  assign rd_irq = io_rd_i && io_addr_i == `FPC_OFS_IRQ;
  assign io_addr = {page_r, row_r, col_r};
  assign io_addr_inc = io_addr + 18'h00001;
  assign any_guard = (|guard_r) || wp_s2_r;

  // ==========================================================
  // Register and sequencing next state
  always_comb begin
    guard_nxt = guard_r;
    ien_nxt = ien_r;
    done_nxt = done_r;
    err_nxt = err_r;
    info_nxt = info_r;
    page_nxt = page_r;
    row_nxt = row_r;
    col_nxt = col_r;
    op_nxt = op_r;
    wr_nxt = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    pe_nxt = 1'b0;
    ae_nxt = 1'b0;
    // Read clears flags before new events so that a set wins
    if (rd_irq) begin
      done_nxt = 1'b0;
      err_nxt = 4'h0;
    end
    if (wr_guard) begin
      if (guard_unlocked_i) begin
        guard_nxt = io_wdata_i;
      end else begin
        guard_nxt = `FPC_LOCKED_GUARD;
      end
    end
    if (wr_irq) begin
      ien_nxt = {io_wdata_i[`FPC_IRQ_COMPLETION_IRQ_ENABLE],
                 io_wdata_i[`FPC_IRQ_ERROR_IRQ_ENABLE]};
    end
    if (wr_page) begin
      info_nxt = io_wdata_i[`FPC_PAGE_INFO];
      page_nxt = io_wdata_i[6:0];
    end
    if (wr_row) begin
      row_nxt = io_wdata_i[2:0];
    end
    if (wr_col) begin
      col_nxt = io_wdata_i;
    end
    // Data port: write with guard check, then step the address
    if (hit_data) begin
      if (io_wr_i) begin
        if (!info_r && blk_guarded(guard_r, wp_s2_r, page_r[6:4])) begin
          err_nxt[`FPC_IRQ_WR_VIOL] = 1'b1;
        end else begin
          wr_nxt = 1'b1;
          waddr_nxt = io_addr;
          wdata_nxt = io_wdata_i;
        end
      end
      {page_nxt, row_nxt, col_nxt} = io_addr_inc;
    end else if (mem_wr_i) begin
      if (blk_guarded(guard_r, wp_s2_r, mem_addr_i[17:15])) begin
        err_nxt[`FPC_IRQ_WR_VIOL] = 1'b1;
      end else begin
        wr_nxt = 1'b1;
        waddr_nxt = mem_addr_i;
        wdata_nxt = mem_wdata_i;
      end
    end
    // Operation sequencing
    unique case (op_r)
      fpc_pkg::FPC_IDLE: begin
        if (wr_cmd && io_wdata_i[`FPC_CMD_ARRAY]) begin
          if (any_guard) begin
            err_nxt[`FPC_IRQ_ARR_VIOL] = 1'b1;
          end else begin
            op_nxt = fpc_pkg::FPC_ARRAY;
            ae_nxt = 1'b1;
          end
        end else if (wr_cmd && io_wdata_i[`FPC_CMD_PAGE]) begin
          if (!info_r && blk_guarded(guard_r, wp_s2_r, page_r[6:4])) begin
            err_nxt[`FPC_IRQ_PG_VIOL] = 1'b1;
          end else begin
            op_nxt = fpc_pkg::FPC_PAGE;
            pe_nxt = 1'b1;
          end
        end else if (wr_cmd && io_wdata_i[`FPC_CMD_ROW]) begin
          op_nxt = fpc_pkg::FPC_ROW;
        end
      end
      fpc_pkg::FPC_ARRAY, fpc_pkg::FPC_PAGE: begin
        if (arr_done_i) begin
          op_nxt = fpc_pkg::FPC_IDLE;
          done_nxt = 1'b1;
        end
      end
      fpc_pkg::FPC_ROW: begin
        if (tmo.expire) begin
          op_nxt = fpc_pkg::FPC_IDLE;
          err_nxt[`FPC_IRQ_TMO] = 1'b1;
        end else if (arr_done_i) begin
          op_nxt = fpc_pkg::FPC_IDLE;
          done_nxt = 1'b1;
        end
      end
    endcase
  end

  // ==========================================================
  // Read data
  always_comb begin
    rdata_nxt = 8'h00;
    if (io_rd_i) begin
      unique case (io_addr_i)
        `FPC_OFS_DATA: rdata_nxt = arr_rdata_i;
        `FPC_OFS_GUARD: rdata_nxt = guard_r;
        `FPC_OFS_IRQ: rdata_nxt = {ien_r, done_r, 1'b0, err_r};
        `FPC_OFS_PAGE: rdata_nxt = {info_r, page_r};
        `FPC_OFS_ROW: rdata_nxt = {5'h00, row_r};
        `FPC_OFS_COL: rdata_nxt = col_r;
        `FPC_OFS_PGCTL: rdata_nxt = {5'h00,
                                     op_r == fpc_pkg::FPC_ROW,
                                     op_r == fpc_pkg::FPC_PAGE,
                                     op_r == fpc_pkg::FPC_ARRAY};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      guard_r <= `FPC_RST_GUARD;
      ien_r <= 2'h0;
      done_r <= 1'b0;
      err_r <= 4'h0;
      info_r <= 1'b0;
      page_r <= 7'h00;
      row_r <= 3'h0;
      col_r <= 8'h00;
      op_r <= fpc_pkg::FPC_IDLE;
      wr_r <= 1'b0;
      waddr_r <= 18'h00000;
      wdata_r <= 8'h00;
      pe_r <= 1'b0;
      ae_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      guard_r <= guard_nxt;
      ien_r <= ien_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      info_r <= info_nxt;
      page_r <= page_nxt;
      row_r <= row_nxt;
      col_r <= col_nxt;
      op_r <= op_nxt;
      wr_r <= wr_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      pe_r <= pe_nxt;
      ae_r <= ae_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign io_rdata_o = rdata_r;
  assign arr_wr_o = wr_r;
  assign arr_addr_o = wr_r ? waddr_r : io_addr;
  assign arr_wdata_o = wdata_r;
  assign arr_info_o = info_r;
  assign arr_page_erase_o = pe_r;
  assign arr_array_erase_o = ae_r;
  assign arr_row_prog_o = (op_r == fpc_pkg::FPC_ROW);
  assign done_irq_o = done_r && ien_r[1];
  assign err_irq_o = (|err_r) && ien_r[0];
endmodule : fpc_ctrl

/* dv/fpc_ctrl_monitor.sv */
// Port checker of the flash guard controller
`timescale 1ns/1ns
module fpc_ctrl_monitor #(
  parameter int unsigned ROW_PROGRAM_TIMEOUT_FLAG_TICKS = 4864
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic wp_pin_i,
  input wire logic fclk_tick_i,
  input wire logic mem_wr_i,
  input wire logic [17:0] mem_addr_i,
  input wire logic arr_done_i,
  input wire logic arr_wr_o,
  input wire logic arr_page_erase_o,
  input wire logic arr_array_erase_o,
  input wire logic arr_row_prog_o,
  input wire logic done_irq_o,
  input wire logic err_irq_o
);
  // ==========================================================
  // Helpers
  logic [1:0] wp_r;
  int unsigned tk_r;
  logic irq_rd;
  assign irq_rd = io_rd_i && io_addr_i == 8'hfb;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= 2'h0;
      tk_r <= 0;
    end else begin
      wp_r <= !wp_pin_i ? 2'h0 : (wp_r == 2'h3 ? wp_r : wp_r + 2'h1);
      tk_r <= !arr_row_prog_o ? 0 : tk_r + (fclk_tick_i ? 1 : 0);
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_done_rise;
    $rose(done_irq_o) |-> $past(arr_done_i) || $past(io_wr_i);
  endproperty
  a_done_rise: assert property (p_done_rise)
    else $error("done irq without cause");
  property p_done_hold;
    done_irq_o && !irq_rd && !io_wr_i |=> done_irq_o;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("done irq dropped early");
  property p_rd_clear;
    irq_rd && !io_wr_i && !mem_wr_i && !arr_done_i && !arr_row_prog_o
      |=> !done_irq_o && !err_irq_o;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("flags not cleared by read");
  property p_wp_blk0;
    wp_r == 2'h3 && wp_pin_i && mem_wr_i && !io_wr_i &&
      mem_addr_i[17:15] == 3'h0 |=> !arr_wr_o;
  endproperty
  a_wp_blk0: assert property (p_wp_blk0)
    else $error("boot block written under wp");
  property p_wr_cause;
    arr_wr_o |-> $past(mem_wr_i) ||
      ($past(io_wr_i) && $past(io_addr_i) == 8'hf6);
  endproperty
  a_wr_cause: assert property (p_wr_cause)
    else $error("array write without request");
  property p_wp_arr;
    wp_r == 2'h3 && wp_pin_i && io_wr_i && io_addr_i == 8'hff &&
      io_wdata_i[0] |=> !arr_array_erase_o;
  endproperty
  a_wp_arr: assert property (p_wp_arr)
    else $error("array erase under wp");
  property p_pe_cause;
    arr_page_erase_o |-> $past(io_wr_i) && $past(io_addr_i) == 8'hff &&
      $past(io_wdata_i[1]);
  endproperty
  a_pe_cause: assert property (p_pe_cause)
    else $error("page erase without command");
  property p_tmo_bound;
    arr_row_prog_o |-> tk_r <= ROW_PROGRAM_TIMEOUT_FLAG_TICKS;
  endproperty
  a_tmo_bound: assert property (p_tmo_bound)
    else $error("row program outlived timeout");
endmodule : fpc_ctrl_monitor
bind fpc_ctrl fpc_ctrl_monitor #(.ROW_PROGRAM_TIMEOUT_FLAG_TICKS(ROW_PROGRAM_TIMEOUT_FLAG_TICKS))
  fpc_ctrl_monitor_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
  .io_wdata_i(io_wdata_i), .wp_pin_i(wp_pin_i), .fclk_tick_i(fclk_tick_i),
  .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i), .arr_done_i(arr_done_i),
  .arr_wr_o(arr_wr_o), .arr_page_erase_o(arr_page_erase_o),
  .arr_array_erase_o(arr_array_erase_o), .arr_row_prog_o(arr_row_prog_o),
  .done_irq_o(done_irq_o), .err_irq_o(err_irq_o));

/* dv/fpc_arr_model.sv */
// Flash array stand-in answering erase and row program starts
`timescale 1ns/1ns
module fpc_arr_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic pe_i,
  input wire logic ae_i,
  input wire logic row_i,
  input wire logic hang_i,
  input wire logic [3:0] dly_i,
  input wire logic [17:0] addr_i,
  output logic [7:0] rdata_o,
  output logic done_o
);
  logic [4:0] cnt_r;
  logic row_q;
  // Read data follows the address so stale values never match
  assign rdata_o = addr_i[7:0] ^ 8'h5a;
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 5'h0;
      row_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      row_q <= row_i;
      done_o <= cnt_r == 5'h1;
      if ((pe_i || ae_i || (row_i && !row_q)) && !hang_i) begin
        cnt_r <= {1'b0, dly_i} + 5'h2;
      end else if (cnt_r != 5'h0) begin
        cnt_r <= cnt_r - 5'h1;
      end
    end
  end
endmodule : fpc_arr_model

/* dv/flash_protect_irq_page_ctrl_tb_top.sv */
// Self-checking bench of the flash guard controller
`timescale 1ns/1ns
module flash_protect_irq_page_ctrl_tb_top;
  logic core_clk_i, resetn_i, io_wr_i, io_rd_i, guard_unlocked_i, wp_pin_i;
  logic fclk_tick_i, mem_wr_i, arr_done_i, arr_wr_o, arr_info_o, hang;
  logic arr_page_erase_o, arr_array_erase_o, arr_row_prog_o;
  logic done_irq_o, err_irq_o, ok;
  logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, mem_wdata_i, arr_rdata_i;
  logic [7:0] arr_wdata_o, m_grd, m_irq, m_pg, d;
  logic [17:0] mem_addr_i, arr_addr_o, a, ad;
  logic [3:0] dly;
  int error_cnt, checks, i, n, tc, seed;
  // ==========================================================
  // Design and array model
  fpc_ctrl #(.ROW_PROGRAM_TIMEOUT_FLAG_TICKS(8)) fpc_ctrl_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .guard_unlocked_i(guard_unlocked_i), .wp_pin_i(wp_pin_i),
    .fclk_tick_i(fclk_tick_i), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i), .arr_rdata_i(arr_rdata_i),
    .arr_done_i(arr_done_i), .arr_wr_o(arr_wr_o), .arr_addr_o(arr_addr_o),
    .arr_wdata_o(arr_wdata_o), .arr_info_o(arr_info_o),
    .arr_page_erase_o(arr_page_erase_o),
    .arr_array_erase_o(arr_array_erase_o), .arr_row_prog_o(arr_row_prog_o),
    .done_irq_o(done_irq_o), .err_irq_o(err_irq_o));
  fpc_arr_model fpc_arr_model_inst (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .pe_i(arr_page_erase_o), .ae_i(arr_array_erase_o),
    .row_i(arr_row_prog_o), .hang_i(hang), .dly_i(dly), .addr_i(arr_addr_o),
    .rdata_o(arr_rdata_i), .done_o(arr_done_i));
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    tc <= (tc + 1) % 5;
    fclk_tick_i <= tc == 0;
  end
  // ==========================================================
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task io(input logic [7:0] ad8, input logic [7:0] dd, input bit w);
    @(posedge core_clk_i);
    io_addr_i <= ad8;
    io_wdata_i <= dd;
    io_wr_i <= w;
    io_rd_i <= !w;
    @(posedge core_clk_i);
    io_wr_i <= 1'b0;
    io_rd_i <= 1'b0;
    #1;
  endtask : io
  task rd_chk(input logic [7:0] ad8, input logic [7:0] exp);
    io(ad8, 8'h00, 1'b0);
    chk(io_rdata_o, exp);
  endtask : rd_chk
  task mem(input logic [17:0] ma, input logic [7:0] md);
    @(posedge core_clk_i);
    mem_addr_i <= ma;
    mem_wdata_i <= md;
    mem_wr_i <= 1'b1;
    @(posedge core_clk_i);
    mem_wr_i <= 1'b0;
    #1;
  endtask : mem
  task irq_chk;
    chk({done_irq_o, err_irq_o}, {m_irq[7] & m_irq[5],
      m_irq[6] & |m_irq[3:0]});
    rd_chk(8'hfb, m_irq);
    m_irq = m_irq & 8'hc0;
  endtask : irq_chk
  task wait_done;
    n = 0;
    while (arr_done_i !== 1'b1 && n < 99) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk(n < 99, 1);
    @(posedge core_clk_i);
    #1;
    m_irq[5] = 1'b1;
  endtask : wait_done
  function automatic logic blk_g(input logic [2:0] b);
    return m_grd[b] || (b == 3'h0 && wp_pin_i);
  endfunction : blk_g
  task close_out;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #8000000;
    error_cnt++;
    close_out();
  end
  // ==========================================================
  // Tests
  initial begin
    {resetn_i, io_wr_i, io_rd_i, guard_unlocked_i, wp_pin_i, mem_wr_i} = 0;
    {io_addr_i, io_wdata_i, mem_wdata_i, mem_addr_i, tc, hang} = 0;
    {error_cnt, checks, fclk_tick_i} = 0;
    dly = 4'h3;
    seed = 32'h6564;
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    m_grd = 8'hff;
    m_irq = 8'h00;
    m_pg = 8'h00;
    rd_chk(8'hfa, m_grd);
    rd_chk(8'hfb, m_irq);
    rd_chk(8'hfc, m_pg);
    rd_chk(8'hf9, 8'h00);
    io(8'hfa, 8'h00, 1'b1);
    rd_chk(8'hfa, 8'hff);
    @(posedge core_clk_i);
    guard_unlocked_i <= 1'b1;
    io(8'hfb, 8'hc0, 1'b1);
    m_irq = 8'hc0;
    $display("test reset and lock done");
    for (i = 0; i < 16; i++) begin
      m_grd = 8'($random(seed));
      io(8'hfa, m_grd, 1'b1);
      a = {3'(i), i[3] ? 15'h7fff : 15'h0000};
      d = 8'($random(seed));
      mem(a, d);
      chk(arr_wr_o, !blk_g(a[17:15]));
      if (arr_wr_o === 1'b1)
        chk({arr_addr_o, arr_wdata_o}, {a, d});
      m_irq[3] = m_irq[3] | blk_g(a[17:15]);
      irq_chk();
    end
    $display("test block writes done");
    for (i = 0; i < 10; i++) begin
      m_grd = 8'($random(seed));
      m_pg = {i[3], i[2:0], 4'($random(seed))};
      dly = 4'($random(seed));
      io(8'hfa, m_grd, 1'b1);
      io(8'hfc, m_pg, 1'b1);
      ok = m_pg[7] || !blk_g(m_pg[6:4]);
      io(8'hff, 8'h02, 1'b1);
      chk(arr_page_erase_o, ok);
      chk(arr_info_o, m_pg[7]);
      if (ok) wait_done();
      else m_irq[1] = 1'b1;
      rd_chk(8'hff, 8'h00);
      irq_chk();
    end
    $display("test page erase done");
    for (i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      wp_pin_i <= i == 1;
      m_grd = (i == 0) ? 8'hff : 8'h00;
      m_pg = {i == 2, 7'h00};
      io(8'hfa, m_grd, 1'b1);
      io(8'hfc, m_pg, 1'b1);
      if (i == 1) begin
        mem(18'h01234, 8'h3c);
        chk(arr_wr_o, 1'b0);
        io(8'hff, 8'h02, 1'b1);
        chk(arr_page_erase_o, 1'b0);
        m_irq[3] = 1'b1;
        m_irq[1] = 1'b1;
      end
      io(8'hff, 8'h01, 1'b1);
      ok = m_grd == 8'h00 && !wp_pin_i;
      chk({arr_array_erase_o, arr_info_o}, {ok, m_pg[7]});
      if (ok) wait_done();
      else m_irq[0] = 1'b1;
      irq_chk();
    end
    $display("test array erase done");
    @(posedge core_clk_i);
    hang <= 1'b1;
    wp_pin_i <= 1'b0;
    io(8'hfb, 8'h40, 1'b1);
    m_irq = 8'h40;
    io(8'hff, 8'h04, 1'b1);
    rd_chk(8'hff, 8'h04);
    n = 0;
    while (arr_row_prog_o === 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk(n < 300, 1);
    rd_chk(8'hff, 8'h00);
    m_irq[2] = 1'b1;
    irq_chk();
    hang <= 1'b0;
    io(8'hfb, 8'h80, 1'b1);
    m_irq = 8'h80;
    io(8'hff, 8'h04, 1'b1);
    wait_done();
    chk(arr_row_prog_o, 1'b0);
    irq_chk();
    $display("test row program done");
    io(8'hfa, 8'h00, 1'b1);
    io(8'hfc, 8'h05, 1'b1);
    io(8'hfd, 8'h07, 1'b1);
    io(8'hfe, 8'hff, 1'b1);
    ad = {7'h05, 3'h7, 8'hff};
    chk(arr_addr_o, ad);
    d = 8'($random(seed));
    io(8'hf6, d, 1'b1);
    chk({arr_wr_o, arr_addr_o, arr_wdata_o}, {1'b1, ad, d});
    ad = ad + 18'h1;
    io(8'hf6, 8'h00, 1'b0);
    chk(io_rdata_o, ad[7:0] ^ 8'h5a);
    chk(arr_addr_o, ad + 18'h1);
    io(8'hfa, 8'hff, 1'b1);
    d = 8'($random(seed));
    io(8'hf6, d, 1'b1);
    chk(arr_wr_o, 1'b0);
    m_irq[3] = 1'b1;
    irq_chk();
    io(8'hfc, 8'h80, 1'b1);
    io(8'hf6, d, 1'b1);
    chk({arr_wr_o, arr_info_o, arr_wdata_o}, {2'b11, d});
    irq_chk();
    $display("test data port done");
    close_out();
  end
endmodule : flash_protect_irq_page_ctrl_tb_top
